// ===== hdl/sirp_pkg.sv
// Shared constants and types of the two-wire register port.
package sirp_pkg;
    localparam int         REG_COUNT    = 64;
    localparam logic [7:0] REG_DEFAULT  = 8'h00;
    localparam logic [7:0] CMD_KEY      = 8'h96;
    localparam logic [7:0] ADDR_RESTORE = 8'h3c;
    localparam logic [7:0] ADDR_TRIM    = 8'h3d;
    localparam logic [3:0] ID_PREFIX    = 4'h0;
    localparam logic       ID_FILL      = 1'b0;
    localparam logic       DIR_READ     = 1'b1;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] BIT_ZERO     = 4'h0;
    localparam logic [3:0] BIT_ONE      = 4'h1;
    localparam logic [7:0] WA_STEP      = 8'h01;
    localparam logic [3:0] PIN_IDLE     = 4'hf;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WADDR,
        ST_WADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } sirp_state_e;
endpackage

// ===== hdl/sirp_sync.sv
// Two-stage synchroniser for pins and for the reset release.
module sirp_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end

    // The first stage feeds only the second, so metastability has a full cycle to settle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule

// ===== hdl/sirp_top.sv
// Two-wire slave register port with auto-incrementing word address and direct commands.
module sirp_top #(
    parameter int REG_COUNT = sirp_pkg::REG_COUNT
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic serial_clock_line_i,
    input  wire logic serial_data_line_i,
    input  wire logic slave_id_select_low,
    input  wire logic slave_id_select_high,
    output logic      serial_data_line_o,
    output logic      serial_data_line_oe,
    output logic      restore_defaults_command,
    output logic      oscillator_trim_command
);
    import sirp_pkg::*;
    localparam int AW = $clog2(REG_COUNT);
    function automatic logic is_cmd(input logic [7:0] wa, input logic [7:0] dat, input logic [7:0] target);
        is_cmd = (wa == target) && (dat == CMD_KEY);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    logic       rst_n;
    logic [3:0] pins_s;
    logic       scl_s, sda_s;
    logic       sel_hi_s, sel_lo_s;

    sirp_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk   (ref_clk), .rst_n (rstn),
        .d     (1'b1),    .q     (rst_n)
    );
    sirp_sync #(.W(4), .RST_VAL(PIN_IDLE)) u_pin_sync (
        .clk   (ref_clk), .rst_n (rst_n),
        .d     ({serial_clock_line_i, serial_data_line_i, slave_id_select_high, slave_id_select_low}),
        .q     (pins_s)
    );

    assign scl_s    = pins_s[3];
    assign sda_s    = pins_s[2];
    assign sel_hi_s = pins_s[1];
    assign sel_lo_s = pins_s[0];
    ////////////////////////////////////////////////////////////////////////////
    logic scl_p_q, scl_p_d;
    logic sda_p_q, sda_p_d;
    logic scl_rise, scl_fall;
    logic start_c, stop_c;

    always_comb begin
        scl_p_d = scl_s;
        sda_p_d = sda_s;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
    ////////////////////////////////////////////////////////////////////////////
    sirp_state_e st_q, st_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  wa_q, wa_d;
    logic        rw_q, rw_d;
    logic        acked_q, acked_d;
    logic        oe_q, oe_d;
    logic        o_q, o_d;
    logic        restore_q, restore_d;
    logic        trim_q, trim_d;
    logic [7:0]  mem_q [REG_COUNT];
    logic [7:0]  mem_d [REG_COUNT];
    logic [7:0]  rd_byte;
    logic        id_match;
    assign rd_byte  = mem_q[wa_q[AW-1:0]];
    assign id_match = sh_q[7:1] == {ID_PREFIX, sel_hi_s, sel_lo_s, ID_FILL};
    always_comb begin
        st_d      = st_q;
        bit_d     = bit_q;
        sh_d      = sh_q;
        wa_d      = wa_q;
        rw_d      = rw_q;
        acked_d   = acked_q;
        oe_d      = oe_q;
        o_d       = 1'b0;
        restore_d = 1'b0;
        trim_d    = 1'b0;
        mem_d     = mem_q;
        if (start_c) begin
            // a repeated start leaves the word address untouched.
            st_d  = ST_ADDR;
            bit_d = BIT_ZERO;
            oe_d  = 1'b0;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            unique case (st_q)
                ST_ADDR, ST_WADDR, ST_WDATA: begin
                    sh_d  = {sh_q[6:0], sda_s};
                    bit_d = bit_q + BIT_ONE;
                end
                ST_RDATA: begin
                    bit_d = bit_q + BIT_ONE;
                end
                ST_RACK: begin
                    acked_d = ~sda_s;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (st_q)
                ST_ADDR: begin
                    if (bit_q == BYTE_BITS) begin
                        if (id_match) begin
                            st_d = ST_ADDR_ACK;
                            rw_d = sh_q[0];
                            oe_d = 1'b1;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_d = BIT_ZERO;
                    if (rw_q == DIR_READ) begin
                        // first byte right after the id acknowledge.
                        // byte taken from the stored word address.
                        st_d = ST_RDATA;
                        sh_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        wa_d = wa_q + WA_STEP;
                    end else begin
                        st_d = ST_WADDR;
                        oe_d = 1'b0;
                    end
                end
                ST_WADDR: begin
                    if (bit_q == BYTE_BITS) begin
                        st_d = ST_WADDR_ACK;
                        wa_d = sh_q;
                        oe_d = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (bit_q == BYTE_BITS) begin
                        st_d = ST_WDATA_ACK;
                        oe_d = 1'b1;
                        // word address advances per data byte.
                        wa_d = wa_q + WA_STEP;
                        // command keys act, they are never stored.
                        if (is_cmd(wa_q, sh_q, ADDR_RESTORE)) begin
                            restore_d = 1'b1;
                            for (int i = 0; i < REG_COUNT; i++) begin
                                mem_d[i] = REG_DEFAULT;
                            end
                        end else if (is_cmd(wa_q, sh_q, ADDR_TRIM)) begin
                            trim_d = 1'b1;
                        end else if (wa_q != ADDR_RESTORE && wa_q != ADDR_TRIM) begin
                            mem_d[wa_q[AW-1:0]] = sh_q;
                        end
                    end
                end
                ST_WADDR_ACK, ST_WDATA_ACK: begin
                    st_d  = ST_WDATA;
                    bit_d = BIT_ZERO;
                    oe_d  = 1'b0;
                end
                ST_RDATA: begin
                    if (bit_q == BYTE_BITS) begin
                        st_d = ST_RACK;
                        oe_d = 1'b0;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
                ST_RACK: begin
                    bit_d = BIT_ZERO;
                    if (acked_q) begin
                        st_d = ST_RDATA;
                        sh_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        wa_d = wa_q + WA_STEP;
                    end else begin
                        st_d = ST_IDLE;
                        oe_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end
    // The array is in the flop group too, so a restore and a write can never both land.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= ST_IDLE;
            bit_q     <= BIT_ZERO;
            sh_q      <= REG_DEFAULT;
            wa_q      <= REG_DEFAULT;
            rw_q      <= 1'b0;
            acked_q   <= 1'b0;
            oe_q      <= 1'b0;
            o_q       <= 1'b0;
            restore_q <= 1'b0;
            trim_q    <= 1'b0;
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_q[i] <= REG_DEFAULT;
            end
        end else begin
            st_q      <= st_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            wa_q      <= wa_d;
            rw_q      <= rw_d;
            acked_q   <= acked_d;
            oe_q      <= oe_d;
            o_q       <= o_d;
            restore_q <= restore_d;
            trim_q    <= trim_d;
            mem_q     <= mem_d;
        end
    end

    assign serial_data_line_o       = o_q;
    assign serial_data_line_oe      = oe_q;
    assign restore_defaults_command = restore_q;
    assign oscillator_trim_command  = trim_q;
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_id_done;
        st_q == ST_ADDR && bit_q == BYTE_BITS && scl_fall && !start_c && !stop_c;
    endsequence
    sequence s_wbyte_done;
        st_q == ST_WDATA && bit_q == BYTE_BITS && scl_fall && !start_c && !stop_c;
    endsequence
    sequence s_read_load;
        ((st_q == ST_ADDR_ACK && rw_q) || (st_q == ST_RACK && acked_q)) && scl_fall && !start_c && !stop_c;
    endsequence
    a_start_opens: assert property (start_c |=> st_q == ST_ADDR && bit_q == BIT_ZERO && !oe_q)
        else $error("start did not open an address phase");
    a_start_keeps_addr: assert property (start_c |=> wa_q == $past(wa_q))
        else $error("repeated start changed the word address");
    a_id_ack: assert property (s_id_done and id_match |=> oe_q && st_q == ST_ADDR_ACK)
        else $error("own identifier not acknowledged");
    a_foreign_id: assert property (s_id_done and !id_match |=> !oe_q && st_q == ST_IDLE ##1 !oe_q)
        else $error("foreign identifier was acknowledged");
    a_write_step: assert property (s_wbyte_done |=> oe_q && wa_q == $past(wa_q) + WA_STEP)
        else $error("write did not advance the address");
    a_read_first: assert property (s_read_load |=> st_q == ST_RDATA && sh_q == $past(rd_byte)
                                   && oe_q == ~$past(rd_byte[7]))
        else $error("read byte not taken from word address");
    a_read_step: assert property (s_read_load |=> wa_q == $past(wa_q) + WA_STEP)
        else $error("read did not advance the address");
    a_nack_release: assert property (st_q == ST_RACK && !acked_q && scl_fall && !start_c && !stop_c
                                     |=> st_q == ST_IDLE && !oe_q)
        else $error("data line held after not-acknowledge");
    a_restore_pulse: assert property (s_wbyte_done and is_cmd(wa_q, sh_q, ADDR_RESTORE)
                                      |=> restore_q && mem_q[0] == REG_DEFAULT ##1 !restore_q)
        else $error("restore command did not pulse");
    a_trim_pulse: assert property (s_wbyte_done and is_cmd(wa_q, sh_q, ADDR_TRIM)
                                   |=> trim_q && !restore_q ##1 !trim_q)
        else $error("trim command did not pulse");
endmodule

// ===== dv/sirp_master.sv
// Behavioural two-wire bus master that drives the register port.
module sirp_master (
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 10ps;
    // A quarter of the 125 ns bus clock; data only moves well inside the low phase.
    localparam realtime Q = 31.25ns;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // start from idle or repeated start
    task automatic start();
        #Q sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
    endtask
    // stop closes the frame, clock then stands high
    task automatic stop();
        #Q sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #Q;
    endtask
    task automatic bit_xfer(input logic b, output logic s);
        #Q sda_oe = ~b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask
    // byte sent high bit first, ninth slot read back as acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask
    // acknowledge to ask for more, not-acknowledge on the last byte
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(~more, s);
    endtask
endmodule

// ===== dv/sensor_i2c_register_port_test.sv
// Self-checking bench of the two-wire register port.
module sensor_i2c_register_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sirp_pkg::*;
    // Select pins high=1, low=0 give these identifiers; the foreign one has the pins swapped.
    localparam logic [7:0] ID_W     = 8'h08;
    localparam logic [7:0] ID_R     = 8'h09;
    localparam logic [7:0] ID_OTHER = 8'h04;
    logic ref_clk;
    logic rstn;
    logic sel_lo;
    logic sel_hi;
    logic scl;
    logic m_oe;
    logic dut_o;
    logic dut_oe;
    logic restore;
    logic trim;
    wire  sda;
    int   miscompares = 0;
    int   n_tests = 0;
    int   cycles = 0;
    int   n_restore = 0;
    int   n_trim = 0;
    // Pull-up on the data line; either party may pull it low.
    assign sda = ~m_oe & (dut_oe ? dut_o : 1'b1);
    sirp_top DUT (
        .ref_clk(ref_clk), .rstn(rstn), .serial_clock_line_i(scl), .serial_data_line_i(sda),
        .slave_id_select_low(sel_lo), .slave_id_select_high(sel_hi), .serial_data_line_o(dut_o),
        .serial_data_line_oe(dut_oe), .restore_defaults_command(restore), .oscillator_trim_command(trim)
    );
    sirp_master M (.scl(scl), .sda_oe(m_oe), .sda(sda));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Counting high cycles also proves each command pulse lasts a single cycle.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (restore === 1'b1) n_restore++;
        if (trim === 1'b1) n_trim++;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
        logic ack;
        M.start();
        M.wbyte(ID_W, ack);
        check("write id ack", 8'h01, {7'h00, ack});
        M.wbyte(a, ack);
        check("word address ack", 8'h01, {7'h00, ack});
        for (int i = n - 1; i >= 0; i--) begin
            M.wbyte(d[i*8 +: 8], ack);
            check("data ack", 8'h01, {7'h00, ack});
        end
        M.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n, output logic [23:0] q);
        logic       ack;
        logic [7:0] b;
        q = '0;
        M.start();
        M.wbyte(ID_W, ack);
        M.wbyte(a, ack);
        check("address ack", 8'h01, {7'h00, ack});
        M.start();
        M.wbyte(ID_R, ack);
        check("read id ack", 8'h01, {7'h00, ack});
        for (int i = n - 1; i >= 0; i--) begin
            M.rbyte(i > 0, b);
            q[i*8 +: 8] = b;
        end
        // Late enough that a port wrongly starting another byte would already drive.
        #60;
        check("data line released", 8'h00, {7'h00, dut_oe});
        M.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_foreign();
        logic ack;
        M.start();
        M.wbyte(ID_OTHER, ack);
        check("foreign id ack", 8'h00, {7'h00, ack});
        M.wbyte(8'h05, ack);
        check("foreign byte ack", 8'h00, {7'h00, ack});
        M.stop();
        $display("test foreign identifier done");
    endtask
    task automatic t_page();
        logic       ack;
        logic [7:0] b;
        logic [23:0] q;
        wr(8'h05, 24'h55aac3, 3);
        rd(8'h05, 2, q);
        check("sequential byte 0", 8'h55, q[15:8]);
        check("sequential byte 1", 8'haa, q[7:0]);
        M.start();
        M.wbyte(ID_R, ack);
        M.rbyte(1'b0, b);
        M.stop();
        check("fresh start read", 8'hc3, b);
        $display("test page write and reads done");
    endtask
    task automatic t_cmd();
        int          r0;
        int          t0;
        logic [23:0] q;
        r0 = n_restore;
        t0 = n_trim;
        wr(ADDR_RESTORE, 24'h000069, 1);
        check("restore after wrong key", 8'h00, 8'(n_restore - r0));
        wr(ADDR_TRIM, {16'h0000, CMD_KEY}, 1);
        check("trim pulse cycles", 8'h01, 8'(n_trim - t0));
        rd(ADDR_RESTORE, 1, q);
        check("command address read", REG_DEFAULT, q[7:0]);
        wr(ADDR_RESTORE, {16'h0000, CMD_KEY}, 1);
        check("restore pulse cycles", 8'h01, 8'(n_restore - r0));
        check("trim after restore", 8'h01, 8'(n_trim - t0));
        rd(8'h05, 2, q);
        check("restored byte 0", REG_DEFAULT, q[15:8]);
        check("restored byte 1", REG_DEFAULT, q[7:0]);
        $display("test direct commands done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b1;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_foreign();
        t_page();
        t_cmd();
        end_sim();
    end
endmodule
